// ===== srq_pkg.sv
package srq_pkg;
  localparam int          DATA_W        = 8;
  localparam int          DEPTH         = 4;
  localparam int          PTR_W         = 2;
  localparam int          CNT_W         = 5;
  localparam logic [4:0]  CNT_MAX       = 5'h04;
  // word index of each register on the plain port
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_DATA     = 4'h1;
  localparam logic [3:0]  ADDR_ISTAT    = 4'h2;
  localparam logic [3:0]  ADDR_IMASK    = 4'h3;
  // field positions of rx_queue_control
  localparam int          OVF_BIT       = 15;
  localparam int          OVF_CLR_BIT   = 14;
  localparam int          QRST_BIT      = 13;
  localparam int          CNT_HI        = 12;
  localparam int          CNT_LO        = 8;
  localparam int          LVL_BIT       = 7;
  localparam int          LVL_CLR_BIT   = 6;
  localparam int          IENA_BIT      = 5;
  localparam int          THR_HI        = 4;
  localparam int          THR_LO        = 0;
  // reset values
  localparam logic        QRST_RST      = 1'b1;
  localparam logic        IENA_RST      = 1'b0;
  localparam logic [4:0]  THR_RST       = 5'h1f;
  // sticky event bits: 0 level match, 1 overrun
  localparam int          EV_N          = 2;
  localparam int          EV_LVL        = 0;
  localparam int          EV_OVR        = 1;
  localparam logic [1:0]  MASK_RST      = 2'h0;
endpackage

// ===== srq_rx_fifo_ctrl.sv
// Notes on behaviour
// RULE1: a push into a full queue sets the overrun flag and drops the oldest word.
// RULE2: the overrun flag in bit 15 is status only and raises no level request.
// RULE3: writing one to bit 14 clears the overrun flag; bit 14 reads zero.
// RULE4: while bit 13 is zero the pointers and count are held at zero.
// RULE5: setting bit 13 to one lets the queue take words again.
// RULE6: bits 12 to 8 report the stored word count, 0 to 4.
// RULE7: bit 7 reads one once the level condition has occurred; the code sets it only while bit 13 is one.
// RULE8: writing one to bit 6 clears the level flag; bit 6 reads zero.
// RULE9: bit 5 enables the level-match request.
// RULE10: the level condition holds when count >= threshold in bits 4 to 0.
// RULE11: the threshold resets to all ones.
// RULE12: software keeps the threshold at four or less.
// RULE13: the queue request is high while level flag and enable are both one; the code registers it, so it follows them one cycle later.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module srq_rx_fifo_ctrl
  import srq_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        pushValid,
  input  wire logic [srq_pkg::DATA_W-1:0]  pushData,
  input  wire logic [3:0]                  regAddr,
  input  wire logic [15:0]                 regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [15:0]                 regRdData,
  output logic                             rxQueueIrq,
  output logic                             irq
);
  import srq_pkg::*;

  logic [PTR_W-1:0]  wrPtr_q;
  logic [PTR_W-1:0]  rdPtr_q;
  logic [CNT_W-1:0]  count_q;
  logic              overrun_q;
  logic              levelFlag_q;
  logic              queueRun_q;
  logic              levelIrqEn_q;
  logic [4:0]        threshold_q;
  logic [EV_N-1:0]   evStat_q;
  logic [EV_N-1:0]   evMask_q;
  logic              bypass_q;
  logic [DATA_W-1:0] bypassData_q;
  logic [DATA_W-1:0] memRdData;
  logic [PTR_W-1:0]  memRdAddr;
  logic [PTR_W-1:0]  rdPtr_d;
  logic [DATA_W-1:0] headWord;

  logic              ctrlWr;
  logic              popReq;
  logic              push;
  logic              pop;
  logic              full;
  logic              dropOld;
  logic              thresholdMatch;
  logic [EV_N-1:0]   evSet;
  logic [15:0]       ctrlView;

  assign ctrlWr = regWr && (regAddr == ADDR_CTRL);
  // reading the data word consumes it
  assign popReq = regRd && (regAddr == ADDR_DATA);
  assign full = (count_q == CNT_MAX);
  assign push = pushValid && queueRun_q; // RULE5
  assign pop = popReq && queueRun_q && (count_q != '0);
  // full queue, no pop: the oldest word is pushed out
  assign dropOld = push && full && !pop; // RULE1
  // next read pointer, shared by the pointer flop and the mem read port
  always_comb
  begin
    rdPtr_d = rdPtr_q;
    if (srst || !queueRun_q) // RULE4
    begin
      rdPtr_d = '0;
    end
    else if (pop || dropOld) // RULE1
    begin
      rdPtr_d = rdPtr_q + 2'h1;
    end
  end

  // read one pointer ahead so the mem register already shows the head word
  assign memRdAddr = rdPtr_d;

  srq_store u_store (
    .clk    (clk),
    .wrEn   (push),
    .wrAddr (wrPtr_q),
    .wrData (pushData),
    .rdAddr (memRdAddr),
    .rdData (memRdData)
  );

  // write pointer
  always_ff @(posedge clk)
  begin
    if (srst || !queueRun_q) // RULE4
    begin
      wrPtr_q <= '0;
    end
    else if (push)
    begin
      wrPtr_q <= wrPtr_q + 2'h1;
    end
  end

  // read pointer; reset and hold are folded into rdPtr_d
  always_ff @(posedge clk)
  begin
    rdPtr_q <= rdPtr_d; // RULE1 RULE4
  end

  // fill count; a push into a full queue leaves it at four
  always_ff @(posedge clk)
  begin
    if (srst || !queueRun_q) // RULE4
    begin
      count_q <= '0;
    end
    else if (push && !pop && !full)
    begin
      count_q <= count_q + 5'h01; // RULE6
    end
    else if (pop && !push)
    begin
      count_q <= count_q - 5'h01; // RULE6
    end
  end

  // a push onto the head address reaches the mem register one edge late;
  // the word is kept here for that single cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bypass_q     <= 1'b0;
      bypassData_q <= '0;
    end
    else
    begin
      bypass_q     <= push && (wrPtr_q == rdPtr_d);
      bypassData_q <= pushData;
    end
  end

  assign headWord = bypass_q ? bypassData_q : memRdData;

  // threshold >= check; limits above four never match, by intent
  assign thresholdMatch = (count_q >= threshold_q); // RULE10

  // overrun flag: set wins over the clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      overrun_q <= 1'b0;
    end
    else if (dropOld) // RULE1
    begin
      overrun_q <= 1'b1;
    end
    else if (ctrlWr && regWrData[OVF_CLR_BIT]) // RULE3
    begin
      overrun_q <= 1'b0;
    end
  end

  // level flag: set wins over the clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      levelFlag_q <= 1'b0;
    end
    else if (thresholdMatch && queueRun_q) // RULE7
    begin
      levelFlag_q <= 1'b1;
    end
    else if (ctrlWr && regWrData[LVL_CLR_BIT]) // RULE8
    begin
      levelFlag_q <= 1'b0;
    end
  end

  // control fields
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      queueRun_q   <= QRST_RST;
      levelIrqEn_q <= IENA_RST;
      threshold_q  <= THR_RST; // RULE11
    end
    else if (ctrlWr)
    begin
      queueRun_q   <= regWrData[QRST_BIT]; // RULE4 RULE5
      levelIrqEn_q <= regWrData[IENA_BIT]; // RULE9
      threshold_q  <= regWrData[THR_HI:THR_LO];
    end
  end

  // request output of the queue; overrun deliberately not ORed in
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rxQueueIrq <= 1'b0;
    end
    else
    begin
      rxQueueIrq <= levelFlag_q && levelIrqEn_q; // RULE13 RULE2 RULE9
    end
  end

  // sticky event status, write one to clear, set wins
  assign evSet[EV_LVL] = thresholdMatch && queueRun_q;
  assign evSet[EV_OVR] = dropOld;

  for (genvar e = 0; e < EV_N; e++)
  begin : g_ev
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        evStat_q[e] <= 1'b0;
      end
      else if (evSet[e])
      begin
        evStat_q[e] <= 1'b1;
      end
      else if (regWr && (regAddr == ADDR_ISTAT) && regWrData[e])
      begin
        evStat_q[e] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      evMask_q <= MASK_RST;
    end
    else if (regWr && (regAddr == ADDR_IMASK))
    begin
      evMask_q <= regWrData[EV_N-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(evStat_q & evMask_q);
    end
  end

  // clear bits read zero
  always_comb
  begin
    ctrlView = '0;
    ctrlView[OVF_BIT]       = overrun_q; // RULE2
    ctrlView[QRST_BIT]      = queueRun_q;
    ctrlView[CNT_HI:CNT_LO] = count_q; // RULE6
    ctrlView[LVL_BIT]       = levelFlag_q; // RULE7
    ctrlView[IENA_BIT]      = levelIrqEn_q;
    ctrlView[THR_HI:THR_LO] = threshold_q;
  end

  // read data stand in the cycle after the strobe only, zero otherwise;
  // a data read of an empty queue returns a stale word and pops nothing
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      regRdData <= '0;
    end
    else if (regRd)
    begin
      case (regAddr)
        ADDR_CTRL:  regRdData <= ctrlView;
        ADDR_DATA:  regRdData <= {8'h00, headWord};
        ADDR_ISTAT: regRdData <= {14'h0000, evStat_q};
        ADDR_IMASK: regRdData <= {14'h0000, evMask_q};
        default:    regRdData <= '0;
      endcase
    end
    else
    begin
      regRdData <= '0;
    end
  end
endmodule
`default_nettype wire

// ===== srq_rx_fifo_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module srq_rx_fifo_ctrl_monitor
  import srq_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       srst,
  input wire logic                       pushValid,
  input wire logic [srq_pkg::DATA_W-1:0] pushData,
  input wire logic [3:0]                 regAddr,
  input wire logic [15:0]                regWrData,
  input wire logic                       regWr,
  input wire logic                       regRd,
  input wire logic [15:0]                regRdData,
  input wire logic                       rxQueueIrq,
  input wire logic                       irq
);
  import srq_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence sCtrlRd;
    regRd && regAddr == ADDR_CTRL ##1 1'b1;
  endsequence
  a_idle_read_zero: assert property (!$past(regRd) |-> regRdData == 16'h0)
    else $error("read data not zero outside read slot");
  a_clear_bits_zero: assert property (sCtrlRd |->
    !regRdData[OVF_CLR_BIT] && !regRdData[LVL_CLR_BIT])
    else $error("clear bit read back as one");
  a_count_max: assert property (sCtrlRd |->
    regRdData[CNT_HI:CNT_LO] <= CNT_MAX) else $error("count above depth");
  a_hold_empty: assert property (sCtrlRd |-> regRdData[QRST_BIT] ||
    regRdData[CNT_HI:CNT_LO] == 5'h00) else $error("count while held");
  a_quiet_reset: assert property ($past(srst) |->
    !rxQueueIrq && !irq) else $error("request high after reset");
  a_thr_reset: assert property ($past(srst, 2) && !$past(srst) &&
    $past(regRd) && $past(regAddr) == ADDR_CTRL |->
    regRdData[THR_HI:THR_LO] == THR_RST) else $error("threshold not ones");
  a_enable_off: assert property (regWr && regAddr == ADDR_CTRL &&
    !regWrData[IENA_BIT] |-> ##2 !rxQueueIrq)
    else $error("request with enable off");
  a_mask_off: assert property (regWr && regAddr == ADDR_IMASK &&
    regWrData[1:0] == 2'h0 |-> ##2 !irq) else $error("irq with mask off");
endmodule
bind srq_rx_fifo_ctrl srq_rx_fifo_ctrl_monitor srq_rx_fifo_ctrl_monitor_i (
  .clk, .srst, .pushValid, .pushData, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .rxQueueIrq, .irq);
`default_nettype wire

// ===== srq_rx_fifo_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module srq_rx_fifo_ctrl_test;
  import srq_pkg::*;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              pushValid;
  logic [DATA_W-1:0] pushData;
  logic [3:0]        regAddr = 4'h0;
  logic [15:0]       regWrData = 16'h0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [15:0]       regRdData;
  logic              rxQueueIrq;
  logic              irq;
  logic [15:0]       v;
  int                nErrors = 0;
  int                nTests = 0;
  int                cyc = 0;
  always #5 clk = ~clk;
  srq_rx_fifo_ctrl srq_rx_fifo_ctrl_i (.clk, .srst, .pushValid, .pushData,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .rxQueueIrq, .irq);
  srq_rx_source srq_rx_source_i (.clk, .pushValid, .pushData);
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // run is about 60 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      nErrors++;
      conclude;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic t_overrun;
    wr(ADDR_CTRL, 16'h2023);
    srq_rx_source_i.burst(8'h10, 5);
    repeat (3) @(posedge clk);
    rd(ADDR_CTRL);
    chk(v, 16'ha4a3);
    chk(16'(rxQueueIrq), 16'h1);
    rd(ADDR_DATA);
    chk(v, 16'h0011);
    wr(ADDR_CTRL, 16'h6044);
    // old threshold still matches at that edge, so the set wins
    rd(ADDR_CTRL);
    chk(v, 16'h2384);
    wr(ADDR_CTRL, 16'h6044);
    rd(ADDR_CTRL);
    chk(v, 16'h2304);
    chk(16'(rxQueueIrq), 16'h0);
    $display("overrun test done");
  endtask
  task automatic t_events;
    rd(ADDR_ISTAT);
    chk(v, 16'h0003);
    chk(16'(irq), 16'h0);
    wr(ADDR_IMASK, 16'h0003);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(irq), 16'h1);
    wr(ADDR_ISTAT, 16'h0003);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(irq), 16'h0);
    rd(ADDR_ISTAT);
    chk(v, 16'h0000);
    wr(ADDR_IMASK, 16'h0000);
    rd(4'h9);
    chk(v, 16'h0000);
    $display("event test done");
  endtask
  task automatic t_hold;
    wr(ADDR_CTRL, 16'h0004);
    srq_rx_source_i.burst(8'h33, 2);
    rd(ADDR_CTRL);
    chk(v, 16'h0004);
    wr(ADDR_CTRL, 16'h2004);
    srq_rx_source_i.burst(8'h5a, 1);
    rd(ADDR_CTRL);
    chk(v, 16'h2104);
    rd(ADDR_DATA);
    chk(v, 16'h005a);
    $display("hold test done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, 16'h201f);
    $display("reset test done");
    t_overrun;
    t_events;
    t_hold;
    conclude;
  end
endmodule
`default_nettype wire

// ===== srq_rx_source.sv
`timescale 1ns/10ps
`default_nettype none
module srq_rx_source
  import srq_pkg::*;
(
  input  wire logic                       clk,
  output var  logic                       pushValid,
  output var  logic [srq_pkg::DATA_W-1:0] pushData
);
  import srq_pkg::*;
  initial
  begin
    pushValid = 1'b0;
    pushData = '0;
  end
  // back-to-back characters, data scrambled once released
  task automatic burst(input logic [DATA_W-1:0] d, input int n);
    repeat (n)
    begin
      @(posedge clk);
      pushValid <= 1'b1;
      pushData <= d;
      d = d + 1'b1;
    end
    @(posedge clk);
    pushValid <= 1'b0;
    pushData <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== srq_store.sv
`timescale 1ns/10ps
`default_nettype none
module srq_store
  import srq_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  wrEn,
  input  wire logic [srq_pkg::PTR_W-1:0]  wrAddr,
  input  wire logic [srq_pkg::DATA_W-1:0] wrData,
  input  wire logic [srq_pkg::PTR_W-1:0]  rdAddr,
  output logic      [srq_pkg::DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // registered read port
  always_ff @(posedge clk)
  begin
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire
